// ==== verilog/mmd_access_params.svh ====
// Purpose: Constants for the indirect MMD access control path.
// Assumes: Clause 22 register numbers are five bits wide.
// Notes:   Included by the package; definitions only.
`ifndef MMD_ACCESS_PARAMS_SVH
`define MMD_ACCESS_PARAMS_SVH

// ====================================================================
// Management register numbers
`define MGMT_ADDR_RSVD   5'h0C
`define MGMT_ADDR_CTRL   5'h0D
`define MGMT_ADDR_DATA   5'h0E

// ====================================================================
// Control register fields and reset values
`define CTRL_FUNC_HI     15
`define CTRL_FUNC_LO     14
`define CTRL_DEV_HI      4
`define CTRL_DEV_LO      0
`define CTRL_RSVD_HI_W   6
`define CTRL_RSVD_LO_W   3
`define RSVD_HI_ZERO     6'h00
`define RSVD_LO_ZERO     3'h0
`define CTRL_RESET_FUNC  2'h0
`define CTRL_RESET_DEV   5'h00
`define RSVD_VALUE       16'h0000
`define DATA_ZERO        16'h0000

// ====================================================================
// Access function codes
`define FUNC_ADDRESS     2'h0
`define FUNC_DATA        2'h1
`define FUNC_DATA_POST_INCREMENT     2'h2
`define FUNC_DATA_WRITE_INCREMENT   2'h3

// ====================================================================
// Address pointers
`define MMD_COUNT        32
`define PTR_RESET        16'h0000
`define PTR_STEP         16'h0001

`endif

// ==== verilog/mmd_access_pkg.sv ====
// Purpose: Types shared by the indirect MMD access control path.
// Assumes: Constants come from the params header.
// Notes:   Holds types only.
`include "mmd_access_params.svh"

package mmd_access_pkg;

  // ==================================================================
  // Access functions and controller states
  typedef enum logic [1:0] {
    FN_ADDRESS        = `FUNC_ADDRESS,
    FN_DATA           = `FUNC_DATA,
    FN_DATA_POST_INC  = `FUNC_DATA_POST_INCREMENT,
    FN_DATA_WRITE_INC = `FUNC_DATA_WRITE_INCREMENT
  } access_function_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } access_state_e;

  // ==================================================================
  // Request carriers
  typedef struct packed {
    logic        write;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_s;

  typedef struct packed {
    logic        write;
    logic [4:0]  dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mmd_cmd_s;

endpackage : mmd_access_pkg

// ==== verilog/mmd_indirect_access_control.sv ====
// Purpose: Indirect access from clause 22 registers to clause 45 MMDs.
// Assumes: One management request at a time; the next waits for ack.
// Notes:   MMD register contents live outside; this block holds the
//          control register and one address pointer per MMD.
//
// Summary of operation
// [R01] Register 0x0C is reserved: reads zero, writes ignored.
// [R02] Every MMD keeps its own address pointer, untouched by others.
// [R03] Control bits 4:0 select the MMD for every data window access.
// [R04] Address function routes data window accesses to the pointer.
// [R05] Other functions route accesses to the MMD register pointed at.
// [R06] Post-increment function bumps pointer after reads and writes.
// [R07] Write-increment function bumps pointer after writes only.
// [R08] Control bits 13:8 and 7:5 are reserved, read-only zero.
// [R09] Control bits 15:14 hold the function; register resets to zero.
// [R10] Data window is a 16-bit read-write register at 0x0E.
// [R11] Post-increment is code 10, write-increment is code 11.
`timescale 1ns/100ps

`include "mmd_access_params.svh"

module mmd_indirect_access_control (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     mgmt_req,
  input  wire mmd_access_pkg::mgmt_req_s mgmt_cmd,
  output logic                          mgmt_ack,
  output logic [15:0]                   mgmt_rdata,
  output logic                          mmd_req,
  output mmd_access_pkg::mmd_cmd_s      mmd_cmd,
  input  wire logic                     mmd_ack,
  input  wire logic [15:0]              mmd_rdata
);

  // ==================================================================
  // State
  mmd_access_pkg::access_state_e    state;
  mmd_access_pkg::access_state_e    next_state;
  mmd_access_pkg::access_function_e access_function;
  mmd_access_pkg::access_function_e next_access_function;
  logic [4:0]                       mmd_select;
  logic [4:0]                       next_mmd_select;
  logic                             next_mgmt_ack;
  logic [15:0]                      next_mgmt_rdata;
  logic                             next_mmd_req;
  mmd_access_pkg::mmd_cmd_s         next_mmd_cmd;
  logic [15:0]                      ptr [`MMD_COUNT];
  logic [15:0]                      cur_ptr;
  logic                             ptr_we;
  logic [4:0]                       ptr_idx;
  logic [15:0]                      ptr_val;
  logic [15:0]                      ctrl_read;
  logic                             take;

  assign take    = mgmt_req && (state == mmd_access_pkg::ST_IDLE);
  assign cur_ptr = ptr[mmd_select]; // R03

  // Reserved fields are forced to zero on read whatever was written.
  assign ctrl_read = {access_function, `RSVD_HI_ZERO, `RSVD_LO_ZERO,
                      mmd_select}; // R08

  // ==================================================================
  // Next-state logic for the control path and the MMD handshake.
  always_comb begin
    next_state           = state;
    next_access_function = access_function;
    next_mmd_select      = mmd_select;
    next_mgmt_ack        = 1'b0;
    next_mgmt_rdata      = mgmt_rdata;
    next_mmd_req         = 1'b0;
    next_mmd_cmd         = mmd_cmd;
    ptr_we               = 1'b0;
    ptr_idx              = mmd_select;
    ptr_val              = cur_ptr;
    unique case (state)
      mmd_access_pkg::ST_IDLE: begin
        if (take) begin
          next_mgmt_ack = 1'b1;
          unique case (mgmt_cmd.addr)
            `MGMT_ADDR_CTRL: begin
              next_mgmt_rdata = ctrl_read;
              if (mgmt_cmd.write) begin
                next_access_function = mmd_access_pkg::access_function_e'(
                  mgmt_cmd.wdata[`CTRL_FUNC_HI:`CTRL_FUNC_LO]); // R09
                next_mmd_select =
                  mgmt_cmd.wdata[`CTRL_DEV_HI:`CTRL_DEV_LO]; // R03
              end
            end
            `MGMT_ADDR_DATA: begin
              if (access_function == mmd_access_pkg::FN_ADDRESS) begin
                next_mgmt_rdata = cur_ptr; // R04
                ptr_we          = mgmt_cmd.write; // R04 R10
                ptr_val         = mgmt_cmd.wdata;
              end else begin
                // Data functions go out to the MMD and wait there.
                next_mgmt_ack      = 1'b0;
                next_mmd_req       = 1'b1; // R05
                next_mmd_cmd.write = mgmt_cmd.write;
                next_mmd_cmd.dev   = mmd_select; // R03
                next_mmd_cmd.addr  = cur_ptr; // R05
                next_mmd_cmd.wdata = mgmt_cmd.wdata;
                next_state         = mmd_access_pkg::ST_WAIT;
              end
            end
            default: begin
              // Register 0x0C and unmapped numbers read zero.
              next_mgmt_rdata = `RSVD_VALUE; // R01
            end
          endcase
        end
      end
      mmd_access_pkg::ST_WAIT: begin
        ptr_idx = mmd_cmd.dev; // R02
        ptr_val = mmd_cmd.addr + `PTR_STEP;
        if (mmd_ack) begin
          next_mgmt_ack   = 1'b1;
          next_mgmt_rdata = mmd_cmd.write ? `DATA_ZERO : mmd_rdata; // R10
          next_state      = mmd_access_pkg::ST_IDLE;
          // Pointer moves only once the access has completed.
          ptr_we = (access_function == mmd_access_pkg::FN_DATA_POST_INC)
                || ((access_function == mmd_access_pkg::FN_DATA_WRITE_INC)
                    && mmd_cmd.write); // R06 R07 R11
        end
      end
    endcase
  end

  // ==================================================================
  // Registers for the control path.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= mmd_access_pkg::ST_IDLE;
      access_function <= mmd_access_pkg::access_function_e'(
                           `CTRL_RESET_FUNC); // R09
      mmd_select      <= `CTRL_RESET_DEV;
      mgmt_ack        <= 1'b0;
      mgmt_rdata      <= `DATA_ZERO;
      mmd_req         <= 1'b0;
      mmd_cmd         <= '0;
    end else begin
      state           <= next_state;
      access_function <= next_access_function;
      mmd_select      <= next_mmd_select;
      mgmt_ack        <= next_mgmt_ack;
      mgmt_rdata      <= next_mgmt_rdata;
      mmd_req         <= next_mmd_req;
      mmd_cmd         <= next_mmd_cmd;
    end
  end

  // ==================================================================
  // One address pointer per MMD; only the addressed entry loads.
  for (genvar g = 0; g < `MMD_COUNT; g++) begin : g_ptr
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ptr[g] <= `PTR_RESET;
      end else if (ptr_we && (ptr_idx == 5'(g))) begin
        ptr[g] <= ptr_val; // R02
      end
    end
  end

  // ==================================================================
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_rsvd_reads_zero: assert property ( // R01
    take && !mgmt_cmd.write && mgmt_cmd.addr == `MGMT_ADDR_RSVD
    |=> mgmt_ack && mgmt_rdata == `RSVD_VALUE)
    else $error("reserved register read not zero");

  chk_ptr_own_entry: assert property ( // R02
    ptr_we |-> ptr_idx == mmd_select)
    else $error("pointer write hit another mmd");

  // A pointer load must leave the neighbouring MMD's pointer alone.
  chk_ptr_others_kept: assert property ( // R02
    ptr_we |=> ptr[$past(ptr_idx) + 5'h01]
               == $past(ptr[ptr_idx + 5'h01]))
    else $error("pointer write disturbed another mmd");

  chk_mmd_select_route: assert property ( // R03
    mmd_req |-> mmd_cmd.dev == mmd_select && state == mmd_access_pkg::ST_WAIT)
    else $error("mmd access not routed to selected mmd");

  chk_addr_func_load: assert property ( // R04
    take && mgmt_cmd.write && mgmt_cmd.addr == `MGMT_ADDR_DATA
    && access_function == mmd_access_pkg::FN_ADDRESS
    |=> mgmt_ack && !mmd_req && ptr[mmd_select] == $past(mgmt_cmd.wdata))
    else $error("address function did not load pointer");

  chk_data_func_issue: assert property ( // R05
    take && mgmt_cmd.addr == `MGMT_ADDR_DATA
    && access_function != mmd_access_pkg::FN_ADDRESS
    |=> mmd_req && !mgmt_ack && mmd_cmd.addr == $past(cur_ptr))
    else $error("data function did not reach mmd register");

  chk_post_inc_step: assert property ( // R06
    state == mmd_access_pkg::ST_WAIT && mmd_ack
    && access_function == mmd_access_pkg::FN_DATA_POST_INC
    |=> ptr[mmd_select] == $past(mmd_cmd.addr) + `PTR_STEP)
    else $error("post increment missing");

  chk_write_inc_read: assert property ( // R07
    state == mmd_access_pkg::ST_WAIT && mmd_ack && !mmd_cmd.write
    && access_function == mmd_access_pkg::FN_DATA_WRITE_INC
    |=> ptr[mmd_select] == $past(cur_ptr))
    else $error("write increment moved pointer on read");

  chk_ctrl_rsvd_zero: assert property ( // R08
    take && !mgmt_cmd.write && mgmt_cmd.addr == `MGMT_ADDR_CTRL
    |=> mgmt_rdata[13:5] == '0)
    else $error("control reserved bits not zero");

  chk_ctrl_func_load: assert property ( // R09
    take && mgmt_cmd.write && mgmt_cmd.addr == `MGMT_ADDR_CTRL
    |=> access_function == $past(mgmt_cmd.wdata[15:14]))
    else $error("function field not loaded");

  chk_window_read_back: assert property ( // R10
    state == mmd_access_pkg::ST_WAIT && mmd_ack && !mmd_cmd.write
    |=> mgmt_ack && mgmt_rdata == $past(mmd_rdata)
    ##1 (!mgmt_ack || $past(take)))
    else $error("data window read value lost");

  chk_write_inc_code: assert property ( // R11
    state == mmd_access_pkg::ST_WAIT && mmd_ack && mmd_cmd.write
    && access_function == 2'h3
    |=> ptr[mmd_select] == $past(mmd_cmd.addr) + `PTR_STEP)
    else $error("code 11 write did not increment");

  cov_post_inc_read: cover property (
    state == mmd_access_pkg::ST_WAIT && mmd_ack && !mmd_cmd.write
    && access_function == mmd_access_pkg::FN_DATA_POST_INC);
  cov_write_inc_write: cover property (
    state == mmd_access_pkg::ST_WAIT && mmd_ack && mmd_cmd.write
    && access_function == mmd_access_pkg::FN_DATA_WRITE_INC);
  cov_addr_then_data: cover property (
    take && mgmt_cmd.addr == `MGMT_ADDR_DATA
    && access_function == mmd_access_pkg::FN_ADDRESS
    ##[1:20] take && mgmt_cmd.addr == `MGMT_ADDR_DATA
    && access_function == mmd_access_pkg::FN_DATA);

endmodule : mmd_indirect_access_control

// ==== bench/mmd_space_model.sv ====
// Purpose: Behavioural stand-in for the MMD register spaces.
// Assumes: One access at a time; command is stable from its request.
// Notes:   Answers promptly or slowly; read data is only valid with ack.
`timescale 1ns/100ps

module mmd_space_model (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     mmd_req,
  input  wire mmd_access_pkg::mmd_cmd_s mmd_cmd,
  input  wire logic                     slow,
  output logic                          mmd_ack,
  output logic [15:0]                   mmd_rdata
);
  // ==================================================================
  // Register store keyed by MMD and register number
  logic [15:0] mem [logic [20:0]];
  logic        busy;
  logic [3:0]  cnt;

  // Data toggles outside the ack cycle so a late sample cannot pass.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mmd_ack   <= 1'b0;
      mmd_rdata <= 16'hFFFF;
      busy      <= 1'b0;
      cnt       <= 4'h0;
    end else begin
      mmd_ack   <= 1'b0;
      mmd_rdata <= ~mmd_rdata;
      if (mmd_req) begin
        busy <= 1'b1;
        cnt  <= slow ? 4'h5 : 4'h0;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy    <= 1'b0;
        mmd_ack <= 1'b1;
        if (mmd_cmd.write)
          mem[{mmd_cmd.dev, mmd_cmd.addr}] = mmd_cmd.wdata;
        mmd_rdata <= mem.exists({mmd_cmd.dev, mmd_cmd.addr}) ?
                     mem[{mmd_cmd.dev, mmd_cmd.addr}] : 16'h0000;
      end
    end
  end
endmodule : mmd_space_model

// ==== bench/mmd_indirect_access_control_test.sv ====
// Purpose: Self-checking bench for the indirect MMD access path.
// Assumes: Management requests are single-cycle pulses, one at a time.
// Notes:   Inputs change on the falling edge; data sits in the model.
`timescale 1ns/100ps

module mmd_indirect_access_control_test;
  logic                      ref_clk;
  logic                      rst_n;
  logic                      mgmt_req;
  mmd_access_pkg::mgmt_req_s mgmt_cmd;
  logic                      mgmt_ack;
  logic [15:0]               mgmt_rdata;
  logic                      mmd_req;
  mmd_access_pkg::mmd_cmd_s  mmd_cmd;
  logic                      mmd_ack;
  logic [15:0]               mmd_rdata;
  logic                      slow;
  int                        n_fail;
  int                        n_compared;

  // ==================================================================
  // Clock, design and far-side model
  always #2 ref_clk = ~ref_clk;

  mmd_indirect_access_control u_mmd_indirect_access_control (
    .ref_clk(ref_clk), .rst_n(rst_n), .mgmt_req(mgmt_req),
    .mgmt_cmd(mgmt_cmd), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
    .mmd_req(mmd_req), .mmd_cmd(mmd_cmd), .mmd_ack(mmd_ack),
    .mmd_rdata(mmd_rdata));

  mmd_space_model u_mmd_space_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .mmd_req(mmd_req),
    .mmd_cmd(mmd_cmd), .slow(slow), .mmd_ack(mmd_ack),
    .mmd_rdata(mmd_rdata));

  // ==================================================================
  // Access tasks; a missing ack within the bound counts as a mismatch.
  task automatic access(input logic wr, input logic [4:0] a,
                        input logic [15:0] d);
    int i;
    mgmt_req       = 1'b1;
    mgmt_cmd.write = wr;
    mgmt_cmd.addr  = a;
    mgmt_cmd.wdata = d;
    @(negedge ref_clk);
    mgmt_req = 1'b0;
    for (i = 0; i < 40 && mgmt_ack !== 1'b1; i++)
      @(negedge ref_clk);
    if (mgmt_ack !== 1'b1) begin
      $display("unexpected missing ack at %0t: %h vs %h", $time, 1'b0,
               1'b1);
      n_fail++;
    end
    @(negedge ref_clk);
  endtask : access

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    access(1'b0, a, 16'h0000);
    n_compared++;
    if (mgmt_rdata !== exp) begin
      $display("unexpected read at %0t: got %h expected %h", $time,
               mgmt_rdata, exp);
      n_fail++;
    end
  endtask : rd

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude;
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // ==================================================================
  // Watchdog: the sequence needs well under 1000 cycles.
  initial begin
    #40000;
    n_fail++;
    conclude();
  end

  // ==================================================================
  // Main sequence.
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    mgmt_req = 1'b0;
    mgmt_cmd = '0;
    slow = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(5'h0C, 16'h0000);
    rd(5'h0D, 16'h0000);
    wr(5'h0C, 16'hFFFF);
    rd(5'h0C, 16'h0000);
    wr(5'h0D, 16'hFFFF);
    rd(5'h0D, 16'hC01F);
    wr(5'h1F, 16'h5A5A);
    rd(5'h1F, 16'h0000);
    // Separate pointers for two MMDs.
    wr(5'h0D, 16'h0001);
    wr(5'h0E, 16'h0010);
    wr(5'h0D, 16'h0002);
    wr(5'h0E, 16'h0020);
    wr(5'h0D, 16'h0001);
    rd(5'h0E, 16'h0010);
    // Plain data function, slow far side.
    slow = 1'b1;
    wr(5'h0D, 16'h4001);
    wr(5'h0E, 16'hAAAA);
    rd(5'h0E, 16'hAAAA);
    wr(5'h0D, 16'h0001);
    rd(5'h0E, 16'h0010);
    // Post-increment on both reads and writes.
    slow = 1'b0;
    wr(5'h0D, 16'h8001);
    wr(5'h0E, 16'h1111);
    rd(5'h0E, 16'h0000);
    wr(5'h0D, 16'h0001);
    rd(5'h0E, 16'h0012);
    wr(5'h0E, 16'h0010);
    // Increment on writes only.
    wr(5'h0D, 16'hC001);
    rd(5'h0E, 16'h1111);
    rd(5'h0E, 16'h1111);
    wr(5'h0E, 16'h2222);
    rd(5'h0E, 16'h0000);
    wr(5'h0D, 16'h0001);
    rd(5'h0E, 16'h0011);
    // Select field routes data to the other MMD's space.
    wr(5'h0D, 16'h4002);
    wr(5'h0E, 16'hBBBB);
    rd(5'h0E, 16'hBBBB);
    wr(5'h0D, 16'h4001);
    rd(5'h0E, 16'h0000);
    wr(5'h0D, 16'h0002);
    rd(5'h0E, 16'h0020);
    conclude();
  end
endmodule : mmd_indirect_access_control_test
